// ==== core/phy_status_summary.sv ====
// module: summary status register bank with apb access and event interrupt
//
// The APB interface to the registers was chosen for this implementation.
`default_nettype none
// Summary of operation
// - false carrier counter register read clears the false carrier latch
// - bit 10 shows signal detect, latched low, follows the live source after reset
// - bit 9 shows descrambler lock, latched low, follows the live source after reset
// - bit 8 page received, set on new page, cleared by expansion read
// - bit 7 interrupt pending, cleared by interrupt source register read
// - bit 6 remote fault, cleared by basic status read or reset
// - bit 5 mirrors jabber detect; summary reads leave it alone
// - bit 4 is one once auto-negotiation has completed
// - bit 3 is one while loopback is enabled
// - bit 2 duplex, one full, valid with link and settled negotiation
// - bit 1 speed, one for ten, same validity as duplex
// - bit 0 mirrors link valid; summary reads leave it alone
module phy_status_summary (
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic [phy_status_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [phy_status_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [phy_status_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // status sources from the transceiver core, same clock
  input wire logic signal_detect,
  input wire logic descrambler_lock,
  input wire logic false_carrier_event,
  input wire logic page_received_event,
  input wire logic internal_int_event,
  input wire logic remote_fault_event,
  input wire logic jabber_detect,
  input wire logic autoneg_complete,
  input wire logic link_valid,
  input wire logic autoneg_full_duplex,
  input wire logic autoneg_speed_10,
  // configuration seen by the transceiver core
  output logic loopback_enable,
  output logic autoneg_enable,
  // level interrupt
  output logic irq
);

  localparam int unsigned STATUS_W = phy_status_pkg::STATUS_W;
  localparam int unsigned CTRL_W = phy_status_pkg::CTRL_W;
  localparam int unsigned EV_W = phy_status_pkg::EV_W;
  localparam int unsigned DATA_W = phy_status_pkg::DATA_W;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic slverr;
    logic [CTRL_W-1:0] control;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic false_carrier;
    logic page_received;
    logic int_pending;
    logic remote_fault;
    logic link_prev;
    logic [STATUS_W-1:0] snapshot;
  } state_s;

  state_s state;
  state_s next_state;

  logic signal_detect_ll;
  logic descr_lock_ll;
  logic [STATUS_W-1:0] summary;
  logic setup;
  logic access;
  logic rd_done;
  logic wr_done;
  logic summary_read;
  logic link_ok;
  logic settled;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // address match on a register index
  function automatic logic hit(
    input logic [phy_status_pkg::ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    hit = (addr == phy_status_pkg::byte_addr(idx));
  endfunction

  // sticky flag: a set in the clear cycle wins over the clear
  function automatic logic sticky(
    input logic cur,
    input logic set,
    input logic clr
  );
    sticky = set | (cur & ~clr);
  endfunction

  // true for any mapped register index
  function automatic logic mapped(
    input logic [phy_status_pkg::ADDR_W-1:0] addr
  );
    mapped = hit(addr, phy_status_pkg::SUMMARY_IDX)
           | hit(addr, phy_status_pkg::EXPANSION_IDX)
           | hit(addr, phy_status_pkg::INT_SOURCE_IDX)
           | hit(addr, phy_status_pkg::BASIC_STATUS_IDX)
           | hit(addr, phy_status_pkg::FALSE_CARRIER_IDX)
           | hit(addr, phy_status_pkg::CONTROL_IDX)
           | hit(addr, phy_status_pkg::EVENT_STATUS_IDX)
           | hit(addr, phy_status_pkg::EVENT_MASK_IDX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb phase decode; the slave never inserts wait states
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign rd_done = access & ~pwrite;
  assign wr_done = access & pwrite;
  assign summary_read = rd_done & hit(paddr, phy_status_pkg::SUMMARY_IDX);

  ////////////////////////////////////////////////////////////////////////////
  // latched-low bits, re-armed by a completed summary read
  latch_low_bit u_signal_detect (
    .clk(clk),
    .reset(reset),
    .source(signal_detect),
    .rearm(summary_read),
    .value(signal_detect_ll)
  );

  latch_low_bit u_descr_lock (
    .clk(clk),
    .reset(reset),
    .source(descrambler_lock),
    .rearm(summary_read),
    .value(descr_lock_ll)
  );

  ////////////////////////////////////////////////////////////////////////////
  // duplex and speed only mean something with a link and with negotiation
  // either switched off or finished; otherwise both read as zero
  assign link_ok = link_valid;
  assign settled = link_ok & (~state.control[phy_status_pkg::CTRL_AN_ENABLE]
                              | autoneg_complete);

  ////////////////////////////////////////////////////////////////////////////
  // summary word assembly; bits above the window read as zero
  always_comb begin
    summary = '0;
    summary[phy_status_pkg::BIT_FALSE_CARRIER] = state.false_carrier;
    summary[phy_status_pkg::BIT_SIGNAL_DETECT] =
      signal_detect_ll;
    summary[phy_status_pkg::BIT_DESCR_LOCK] = descr_lock_ll;
    summary[phy_status_pkg::BIT_PAGE_RX] = state.page_received;
    summary[phy_status_pkg::BIT_INT_PENDING] =
      state.int_pending;
    summary[phy_status_pkg::BIT_REMOTE_FAULT] =
      state.remote_fault;
    summary[phy_status_pkg::BIT_JABBER] = jabber_detect;
    summary[phy_status_pkg::BIT_AN_COMPLETE] = autoneg_complete;
    summary[phy_status_pkg::BIT_LOOPBACK] =
      state.control[phy_status_pkg::CTRL_LOOPBACK];
    if (settled) begin
      if (state.control[phy_status_pkg::CTRL_AN_ENABLE]) begin
        summary[phy_status_pkg::BIT_DUPLEX] =
          autoneg_full_duplex;
        summary[phy_status_pkg::BIT_SPEED] = autoneg_speed_10;
      end else begin
        summary[phy_status_pkg::BIT_DUPLEX] =
          state.control[phy_status_pkg::CTRL_FORCE_FULL];
        summary[phy_status_pkg::BIT_SPEED] =
          state.control[phy_status_pkg::CTRL_FORCE_10];
      end
    end
    summary[phy_status_pkg::BIT_LINK] = link_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: read data capture, clear-on-read, writes and event latches
  always_comb begin
    logic clr_fc;
    logic clr_page;
    logic clr_int;
    logic clr_rf;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    clr_fc = 1'b0;
    clr_page = 1'b0;
    clr_int = 1'b0;
    clr_rf = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    next_state = state;
    next_state.link_prev = link_valid;

    // read data is taken in the setup cycle and held through the access
    // cycle; the summary snapshot tells the clears what software has seen
    if (setup) begin
      next_state.rdata = phy_status_pkg::ZERO_WORD;
      next_state.slverr = ~mapped(paddr);
      next_state.snapshot = summary;
      if (!pwrite) begin
        if (hit(paddr, phy_status_pkg::SUMMARY_IDX)) begin
          next_state.rdata[STATUS_W-1:0] = summary;
        end else if (hit(paddr, phy_status_pkg::CONTROL_IDX)) begin
          next_state.rdata[CTRL_W-1:0] = state.control;
        end else if (hit(paddr, phy_status_pkg::EVENT_STATUS_IDX)) begin
          next_state.rdata[EV_W-1:0] = state.ev_status;
        end else if (hit(paddr, phy_status_pkg::EVENT_MASK_IDX)) begin
          next_state.rdata[EV_W-1:0] = state.ev_mask;
        end
      end
    end

    // reads of the source registers clear the mirrored flags; only a flag
    // value that existed at setup time is cleared, so an event landing in
    // the access cycle survives
    if (rd_done) begin
      clr_fc = hit(paddr, phy_status_pkg::FALSE_CARRIER_IDX)
             & state.snapshot[phy_status_pkg::BIT_FALSE_CARRIER];
      clr_page = hit(paddr, phy_status_pkg::EXPANSION_IDX)
               & state.snapshot[phy_status_pkg::BIT_PAGE_RX];
      clr_int = hit(paddr, phy_status_pkg::INT_SOURCE_IDX)
              & state.snapshot[phy_status_pkg::BIT_INT_PENDING];
      clr_rf = hit(paddr, phy_status_pkg::BASIC_STATUS_IDX)
             & state.snapshot[phy_status_pkg::BIT_REMOTE_FAULT];
    end

    next_state.false_carrier =
      sticky(state.false_carrier, false_carrier_event, clr_fc);
    next_state.page_received =
      sticky(state.page_received, page_received_event, clr_page);
    next_state.int_pending =
      sticky(state.int_pending, internal_int_event, clr_int);
    next_state.remote_fault =
      sticky(state.remote_fault, remote_fault_event, clr_rf);

    // writes: only lane 0 carries register bits; the summary and source
    // addresses accept the write and change nothing
    if (wr_done && pstrb[0]) begin
      if (hit(paddr, phy_status_pkg::CONTROL_IDX)) begin
        next_state.control = pwdata[CTRL_W-1:0];
      end else if (hit(paddr, phy_status_pkg::EVENT_STATUS_IDX)) begin
        ev_clr = pwdata[EV_W-1:0];
      end else if (hit(paddr, phy_status_pkg::EVENT_MASK_IDX)) begin
        next_state.ev_mask = pwdata[EV_W-1:0];
      end
    end

    // interrupt events; write-one-to-clear loses to a same-cycle event
    ev_set[phy_status_pkg::EV_LINK] = link_valid ^ state.link_prev;
    ev_set[phy_status_pkg::EV_REMOTE_FAULT] = remote_fault_event;
    ev_set[phy_status_pkg::EV_PAGE_RX] = page_received_event;
    ev_set[phy_status_pkg::EV_FALSE_CARRIER] = false_carrier_event;
    next_state.ev_status = ev_set | (state.ev_status & ~ev_clr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; every flag starts at zero except the autoneg enable bit of control
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
      state.control <= phy_status_pkg::CTRL_RESET;
      state.ev_mask <= phy_status_pkg::EV_MASK_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; read data comes straight from a flop so it cannot glitch, and
  // the error flag is gated by the access phase so an idle bus never shows
  // a stale refusal
  assign prdata = state.rdata;
  assign pslverr = state.slverr & access;
  assign pready = access; // zero wait states
  assign loopback_enable = state.control[phy_status_pkg::CTRL_LOOPBACK];
  assign autoneg_enable = state.control[phy_status_pkg::CTRL_AN_ENABLE];
  assign irq = |(state.ev_status & state.ev_mask);

endmodule
`default_nettype wire

// ==== shared/phy_status_pkg.sv ====
// package: register map, field layout and reset values of the summary block
`default_nettype none
package phy_status_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned STATUS_W = 16;
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned EV_W = 4;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] SUMMARY_IDX = 8'h10;
  localparam logic [7:0] EXPANSION_IDX = 8'h06;
  localparam logic [7:0] INT_SOURCE_IDX = 8'h12;
  localparam logic [7:0] BASIC_STATUS_IDX = 8'h01;
  localparam logic [7:0] FALSE_CARRIER_IDX = 8'h14;
  localparam logic [7:0] CONTROL_IDX = 8'h20;
  localparam logic [7:0] EVENT_STATUS_IDX = 8'h21;
  localparam logic [7:0] EVENT_MASK_IDX = 8'h22;

  // summary register bit positions
  localparam int unsigned BIT_FALSE_CARRIER = 11;
  localparam int unsigned BIT_SIGNAL_DETECT = 10;
  localparam int unsigned BIT_DESCR_LOCK = 9;
  localparam int unsigned BIT_PAGE_RX = 8;
  localparam int unsigned BIT_INT_PENDING = 7;
  localparam int unsigned BIT_REMOTE_FAULT = 6;
  localparam int unsigned BIT_JABBER = 5;
  localparam int unsigned BIT_AN_COMPLETE = 4;
  localparam int unsigned BIT_LOOPBACK = 3;
  localparam int unsigned BIT_DUPLEX = 2;
  localparam int unsigned BIT_SPEED = 1;
  localparam int unsigned BIT_LINK = 0;

  // control register fields
  localparam int unsigned CTRL_LOOPBACK = 0;
  localparam int unsigned CTRL_AN_ENABLE = 1;
  localparam int unsigned CTRL_FORCE_FULL = 2;
  localparam int unsigned CTRL_FORCE_10 = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h2;

  // event status / mask fields
  localparam int unsigned EV_LINK = 0;
  localparam int unsigned EV_REMOTE_FAULT = 1;
  localparam int unsigned EV_PAGE_RX = 2;
  localparam int unsigned EV_FALSE_CARRIER = 3;
  localparam logic [EV_W-1:0] EV_MASK_RESET = 4'h0;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction

endpackage
`default_nettype wire

// ==== core/latch_low_bit.sv ====
// module: one read-only latch-low status bit with read re-arm
`default_nettype none
module latch_low_bit (
  input wire logic clk,
  input wire logic reset,
  input wire logic source,
  input wire logic rearm,
  output logic value
);

  typedef struct packed {
    logic prev;
    logic low_seen;
  } state_s;

  state_s state;
  state_s next_state;

  ////////////////////////////////////////////////////////////////////////////
  // a fall of the source is held until the summary register is read; a fall
  // in the same cycle as the read wins so the drop is never lost
  always_comb begin
    next_state = state;
    next_state.prev = source;
    if (rearm) begin
      next_state.low_seen = 1'b0;
    end
    if (state.prev && !source) begin
      next_state.low_seen = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live source, forced low while a drop is latched
  assign value = source & ~state.low_seen;

endmodule
`default_nettype wire

// ==== testbench/phy_status_checker.sv ====
// checker: port relations of the summary status register bank
`default_nettype none
module phy_status_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic jabber_detect,
  input wire logic autoneg_complete,
  input wire logic link_valid,
  input wire logic loopback_enable,
  input wire logic autoneg_enable,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // completed summary read and write; mirrors were captured one edge earlier
  sequence sum_rd;
    psel && penable && !pwrite && paddr == 12'h040;
  endsequence
  sequence sum_wr;
    psel && penable && pwrite && paddr == 12'h040;
  endsequence
  ready_no_wait_a: assert property (psel && penable |-> pready)
    else $error("pready missing in access cycle");
  reset_state_a: assert property ($fell(reset) |->
    !irq && !loopback_enable && autoneg_enable)
    else $error("outputs wrong after reset");
  link_mirror_a: assert property (
    sum_rd |-> prdata[0] == $past(link_valid))
    else $error("link bit differs from link input");
  jabber_mirror_a: assert property (
    sum_rd |-> prdata[5] == $past(jabber_detect))
    else $error("jabber bit differs from input");
  an_done_a: assert property (
    sum_rd |-> prdata[4] == $past(autoneg_complete))
    else $error("negotiation done bit wrong");
  loop_mirror_a: assert property (
    sum_rd |-> prdata[3] == loopback_enable)
    else $error("loopback bit wrong");
  nolink_mode_a: assert property (
    sum_rd ##0 !$past(link_valid) |-> prdata[2:1] == 2'h0)
    else $error("duplex or speed shown without link");
  upper_zero_a: assert property (
    sum_rd |-> prdata[31:12] == 20'h0 && !pslverr)
    else $error("summary upper bits or error set");
  write_ignored_a: assert property (
    sum_wr |=> $stable(loopback_enable) && $stable(autoneg_enable))
    else $error("summary write changed control");
  unmapped_err_a: assert property (
    psel && penable && paddr == 12'hffc |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule
bind phy_status_summary phy_status_checker i_chk (.clk(clk), .reset(reset),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .jabber_detect(jabber_detect), .autoneg_complete(autoneg_complete),
  .link_valid(link_valid), .loopback_enable(loopback_enable),
  .autoneg_enable(autoneg_enable), .irq(irq));
`default_nettype wire

// ==== testbench/phy_status_summary_tb_top.sv ====
// testbench: random register traffic checked against a summary model
`default_nettype none
module phy_status_summary_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, loopback_enable, autoneg_enable, irq, er;
  logic [6:0] lv = 7'h00; // detect, lock, jabber, an done, link, full, ten
  logic [3:0] ev = 4'h0; // false carrier, page, interrupt, remote fault
  int err_total = 0;
  int n_checks = 0;
  bit fc, pr, ip, rf, sd_hold, dl_hold;
  bit [3:0] ctrl, evs, mask;
  localparam logic [11:0] OPS [8] = '{12'h050, 12'h018, 12'h048, 12'h004,
    12'h040, 12'hffc, 12'h080, 12'h084};
  phy_status_summary i_dut (.clk(clk), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .signal_detect(lv[6]), .descrambler_lock(lv[5]),
    .false_carrier_event(ev[3]), .page_received_event(ev[2]),
    .internal_int_event(ev[1]), .remote_fault_event(ev[0]),
    .jabber_detect(lv[4]), .autoneg_complete(lv[3]), .link_valid(lv[2]),
    .autoneg_full_duplex(lv[1]), .autoneg_speed_10(lv[0]),
    .loopback_enable(loopback_enable), .autoneg_enable(autoneg_enable),
    .irq(irq));
  // 20 MHz clock
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer: the request stands until pready is seen at a rising
  // edge; the answer is taken at that edge and only then is it released
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected summary word from model state and live levels
  function automatic logic [31:0] exp_sum();
    logic [31:0] s;
    bit v;
    v = lv[2] && (!ctrl[1] || lv[3]);
    s = 32'h0;
    s[11] = fc;
    s[10] = lv[6] && !sd_hold;
    s[9] = lv[5] && !dl_hold;
    s[8] = pr;
    s[7] = ip;
    s[6] = rf;
    s[5] = lv[4];
    s[4] = lv[3];
    s[3] = ctrl[0];
    s[2] = v && (ctrl[1] ? lv[1] : ctrl[2]);
    s[1] = v && (ctrl[1] ? lv[0] : ctrl[3]);
    s[0] = lv[2];
    return s;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: levels, pulses, one read in rotation over eight addresses, one random write, plus a mask write after a write to the unmapped address
  initial begin
    logic [31:0] x, w;
    bit [6:0] l;
    bit [3:0] e;
    int k;
    x = $urandom(32'h223f);
    ctrl = 4'h2;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, 12'h080, 32'h0);
    chk("control reset", rd, 32'h2);
    apb(1'b0, 12'h088, 32'h0);
    chk("mask reset", rd, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk("summary reset", rd, 32'h0);
    for (int i = 0; i < 96; i++) begin
      l = 7'($urandom);
      e = 4'($urandom);
      @(posedge clk);
      sd_hold |= lv[6] & ~l[6];
      dl_hold |= lv[5] & ~l[5];
      if (lv[2] != l[2]) evs[0] = 1'b1;
      lv <= l;
      ev <= e;
      @(posedge clk);
      ev <= 4'h0;
      {fc, pr, ip, rf} = {fc, pr, ip, rf} | e;
      evs |= {e[3], e[2], e[0], 1'b0};
      k = i % 8;
      x = (k == 4) ? exp_sum() : 32'h0;
      if (k == 6) x = {28'h0, ctrl};
      if (k == 7) x = {28'h0, evs};
      apb(1'b0, OPS[k], 32'h0);
      chk("read data", rd, x);
      chk("slave error", {31'h0, er}, {31'h0, k == 5});
      case (k)
        0: fc = 1'b0;
        1: pr = 1'b0;
        2: ip = 1'b0;
        3: rf = 1'b0;
        4: {sd_hold, dl_hold} = 2'b00;
        default: ;
      endcase
      w = $urandom;
      k = $urandom_range(3, 0);
      apb(1'b1, OPS[k + 4], w);
      chk("write error", {31'h0, er}, {31'h0, k == 1});
      if (k == 2) ctrl = w[3:0];
      if (k == 3) evs &= ~w[3:0];
      if (k == 1) begin
        apb(1'b1, 12'h088, w);
        mask = w[3:0];
      end
      @(negedge clk);
      chk("irq", {31'h0, irq}, {31'h0, |(evs & mask)});
      chk("control out", {30'h0, autoneg_enable, loopback_enable},
        {30'h0, ctrl[1:0]});
    end
    stop_test();
  end
endmodule
`default_nettype wire
